/* File: inc/hs_caps_pkg.sv */
// constants and carrier types for the high-speed host capability register bank
package hs_caps_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register window
  localparam int          ADDR_W            = 8;
  localparam int          DATA_W            = 32;
  localparam logic [7:0]  OFS_STRUCT_PARAMS = 8'h04;
  localparam logic [7:0]  OFS_CAP_PARAMS    = 8'h08;
  localparam logic [7:0]  OFS_ROUTE_LO      = 8'h0C;
  localparam logic [7:0]  OFS_ROUTE_HI      = 8'h10;
  localparam logic [7:0]  OFS_COMMAND       = 8'h20;
  localparam logic [7:0]  OFS_PORT_POWER    = 8'h40;

  ////////////////////////////////////////////////////////////////////////////
  // structural parameter fields
  localparam int          MAX_PORTS         = 15;
  localparam int          NIB_W             = 4;
  localparam int          ROUTE_W           = MAX_PORTS * NIB_W;
  localparam int          SP_NPORTS_LSB     = 0;
  localparam int          SP_PPS_BIT        = 4;
  localparam int          SP_RR_BIT         = 7;
  localparam int          SP_PPC_LSB        = 8;
  localparam int          SP_NCC_LSB        = 12;

  ////////////////////////////////////////////////////////////////////////////
  // capability parameter fields
  localparam int          CP_WIDE_BIT       = 0;
  localparam int          CP_PFL_BIT        = 1;
  localparam int          CP_IST_LSB        = 4;
  localparam logic [3:0]  IST_RESET         = 4'h1;
  localparam logic        PFL_RESET         = 1'b1;
  localparam logic        WIDE_RESET        = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // command register frame list size
  localparam int          CMD_FLS_LSB       = 2;
  localparam logic [1:0]  FLS_1024          = 2'h0;
  localparam logic [1:0]  FLS_512           = 2'h1;
  localparam logic [1:0]  FLS_256           = 2'h2;
  localparam logic [10:0] LEN_1024          = 11'h400;
  localparam logic [10:0] LEN_512           = 11'h200;
  localparam logic [10:0] LEN_256           = 11'h100;

  // one register access from host software
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              rd;
    logic              wr;
    logic [DATA_W-1:0] wdata;
  } reg_req_s;

  // read answer
  typedef struct packed {
    logic              valid;
    logic [DATA_W-1:0] data;
  } reg_rsp_s;

endpackage : hs_caps_pkg

/* File: hdl/hs_host_capability_params.sv */
// capability and structural parameter register bank with route and power outputs
`timescale 1ns/100ps
module hs_host_capability_params #(
  parameter logic [3:0]  NUM_PORTS     = 4'h2,
  parameter logic [3:0]  PORTS_PER_CC  = 4'h2,
  parameter logic [3:0]  NUM_CC        = 4'h1,
  parameter logic        ROUTE_RULE    = 1'b1,
  parameter logic        POWER_SWITCH  = 1'b1,
  parameter logic [59:0] ROUTE_TABLE   = 60'h0
) (
  input  wire logic                           CORE_CLK,
  input  wire logic                           RST_N,
  input  wire hs_caps_pkg::reg_req_s          REG_REQ,
  output      hs_caps_pkg::reg_rsp_s          REG_RSP,
  output      logic [hs_caps_pkg::ROUTE_W-1:0] PORT_COMPANION,
  output      logic [hs_caps_pkg::MAX_PORTS-1:0] PORT_POWER,
  output      logic [10:0]                    FRAME_LIST_LEN
);
  import hs_caps_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // fixed field values
  localparam logic [3:0] PORTS_RPT = (NUM_PORTS == 4'h0) ? 4'h1 : NUM_PORTS;
  localparam logic [3:0] GROUP     = (PORTS_PER_CC == 4'h0) ? 4'h1 : PORTS_PER_CC;

  logic [DATA_W-1:0]    struct_val;
  logic [DATA_W-1:0]    cap_val;
  logic [ROUTE_W-1:0]   route_val;
  logic [MAX_PORTS-1:0] port_mask;

  // structural word: count, power switch flag, routing flag, group size
  always_comb begin
    struct_val = '0;
    struct_val[SP_NPORTS_LSB +: NIB_W] = PORTS_RPT;
    struct_val[SP_PPS_BIT]             = POWER_SWITCH;
    struct_val[SP_RR_BIT]              = ROUTE_RULE;
    struct_val[SP_PPC_LSB +: NIB_W]    = GROUP;
    struct_val[SP_NCC_LSB +: NIB_W]    = NUM_CC;
  end

  // capability word reset image
  always_comb begin
    cap_val = '0;
    cap_val[CP_IST_LSB +: NIB_W] = IST_RESET;
    cap_val[CP_PFL_BIT]          = PFL_RESET;
    cap_val[CP_WIDE_BIT]         = WIDE_RESET;
  end

  // per-port companion index and implemented-port mask
  genvar gi;
  generate
    for (gi = 0; gi < MAX_PORTS; gi++) begin : g_port
      // group index for consecutive routing, wrapped to one nibble
      localparam logic [3:0] CONSEC = 4'((gi / int'(GROUP)) & 15);
      // a port exists only below the reported count
      localparam logic       HERE   = (gi < int'(PORTS_RPT));
      logic [NIB_W-1:0] table_idx;
      logic [NIB_W-1:0] pick_idx;

      // explicit entry from the route table
      assign table_idx = ROUTE_TABLE[gi*NIB_W +: NIB_W];
      // routing flag picks table entry or consecutive group
      assign pick_idx  = ROUTE_RULE ? table_idx : CONSEC;
      // absent ports read zero and stay unpowered
      assign route_val[gi*NIB_W +: NIB_W] = HERE ? pick_idx : 4'h0;
      assign port_mask[gi]                = HERE;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // register state
  logic [DATA_W-1:0]    cap_q;
  logic [ROUTE_W-1:0]   route_q;
  logic [1:0]           fls_q,   fls_d;
  logic [10:0]          len_q,   len_d;
  logic [MAX_PORTS-1:0] pwr_q,   pwr_d;
  logic [MAX_PORTS-1:0] power_q, power_d;
  reg_rsp_s             rsp_q,   rsp_d;

  // capability word; never takes a write
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cap_q <= {24'h0, IST_RESET, 2'h0, PFL_RESET, WIDE_RESET};
    end else begin
      cap_q <= cap_val;
    end
  end

  // companion route word; zero in reset, table or groups after
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      route_q <= '0;
    end else begin
      route_q <= route_val;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // address decode
  localparam int FLS_W = 2;                                   // size field width
  localparam int HI_W  = ROUTE_W - DATA_W;                    // ports 8 to 14

  logic wr_cmd;
  logic wr_pwr;

  // one strobe per writable register; any other write falls away
  always_comb begin
    wr_cmd = REG_REQ.wr && (REG_REQ.addr == OFS_COMMAND);
    wr_pwr = REG_REQ.wr && (REG_REQ.addr == OFS_PORT_POWER);
  end

  ////////////////////////////////////////////////////////////////////////////
  // command group
  // size field writable only with the programmable flag set
  always_comb begin
    fls_d = fls_q;
    if (wr_cmd) begin
      if (cap_q[CP_PFL_BIT]) begin
        fls_d = REG_REQ.wdata[CMD_FLS_LSB +: FLS_W];
      end else begin
        fls_d = FLS_1024;
      end
    end
    case (fls_d)
      FLS_512: len_d = LEN_512;
      FLS_256: len_d = LEN_256;
      default: len_d = LEN_1024;
    endcase
  end

  // size field and honoured length
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      fls_q <= FLS_1024;
      len_q <= LEN_1024;
    end else begin
      fls_q <= fls_d;
      len_q <= len_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // port power group
  // written bits with switches, every present port on without them
  always_comb begin
    pwr_d = pwr_q;
    if (wr_pwr) begin
      pwr_d = REG_REQ.wdata[MAX_PORTS-1:0];
    end
    power_d = (POWER_SWITCH ? pwr_d : {MAX_PORTS{1'b1}}) & port_mask;
  end

  // stored and applied power bits
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pwr_q   <= '0;
      power_q <= '0;
    end else begin
      pwr_q   <= pwr_d;
      power_q <= power_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read answer
  logic [DATA_W-1:0] cmd_word;
  logic [DATA_W-1:0] hi_word;
  logic [DATA_W-1:0] pwr_word;
  logic [DATA_W-1:0] rd_word;

  // command word: only the size field, reserved bits zero
  always_comb begin
    cmd_word = '0;
    cmd_word[CMD_FLS_LSB +: FLS_W] = fls_q;
  end

  // upper route word: ports 8 to 14, top nibble zero
  always_comb begin
    hi_word = '0;
    hi_word[HI_W-1:0] = route_q[ROUTE_W-1:DATA_W];
  end

  // power word: applied state, so a switchless port reads on
  always_comb begin
    pwr_word = '0;
    pwr_word[MAX_PORTS-1:0] = power_q;
  end

  // read word per offset; a read beside a write sees the old value
  always_comb begin
    case (REG_REQ.addr)
      OFS_STRUCT_PARAMS: rd_word = struct_val;
      OFS_CAP_PARAMS:    rd_word = cap_q;
      OFS_ROUTE_LO:      rd_word = route_q[DATA_W-1:0];
      OFS_ROUTE_HI:      rd_word = hi_word;
      OFS_COMMAND:       rd_word = cmd_word;
      OFS_PORT_POWER:    rd_word = pwr_word;
      default:           rd_word = '0;
    endcase
    rsp_d = '0;
    if (REG_REQ.rd) begin
      rsp_d.valid = 1'b1;
      rsp_d.data  = rd_word;
    end
  end

  // answer pulse and data, one cycle after the read
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rsp_q <= '0;
    end else begin
      rsp_q <= rsp_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from flops
  assign REG_RSP        = rsp_q;
  assign PORT_COMPANION = route_q;
  assign PORT_POWER     = power_q;
  assign FRAME_LIST_LEN = len_q;

endmodule : hs_host_capability_params

/* File: verif/hs_host_capability_params_asserts.sv */
// port assertions for the capability register bank
`timescale 1ns/100ps
module hs_caps_asserts
  import hs_caps_pkg::*;
#(
  parameter logic [3:0] NUM_PORTS    = 4'h2,
  parameter logic       POWER_SWITCH = 1'b1
) (
  input wire logic                              CORE_CLK,
  input wire logic                              RST_N,
  input wire hs_caps_pkg::reg_req_s             REG_REQ,
  input wire hs_caps_pkg::reg_rsp_s             REG_RSP,
  input wire logic [hs_caps_pkg::ROUTE_W-1:0]   PORT_COMPANION,
  input wire logic [hs_caps_pkg::MAX_PORTS-1:0] PORT_POWER,
  input wire logic [10:0]                       FRAME_LIST_LEN
);
  ////////////////////////////////////////////////////////////////////////////
  // helper values
  logic [14:0] pmask;
  logic [14:0] wpow;
  logic [1:0]  frame_list_size;
  assign pmask = 15'((16'h1 << NUM_PORTS) - 16'h1);
  assign wpow  = REG_REQ.wdata[14:0];
  assign frame_list_size   = REG_REQ.wdata[3:2];
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  ////////////////////////////////////////////////////////////////////////////
  // properties
  AST_RD_ANSWER: assert property (REG_REQ.rd |=> REG_RSP.valid)
    else $error("read not answered");
  AST_NO_SPURIOUS: assert property (!REG_REQ.rd |=> !REG_RSP.valid && REG_RSP.data == '0)
    else $error("answer without read");
  AST_CAP_WORD: assert property (REG_REQ.rd && REG_REQ.addr == OFS_CAP_PARAMS |=> REG_RSP.data == 32'h12)
    else $error("capability word wrong");
  AST_PORT_COUNT: assert property (REG_REQ.rd && REG_REQ.addr == OFS_STRUCT_PARAMS |=> REG_RSP.data[3:0] == NUM_PORTS && REG_RSP.data[3:0] != 4'h0)
    else $error("port count wrong");
  AST_POWER_FLAG: assert property (REG_REQ.rd && REG_REQ.addr == OFS_STRUCT_PARAMS |=> REG_RSP.data[SP_PPS_BIT] == POWER_SWITCH && REG_RSP.data[31:16] == 16'h0)
    else $error("power flag wrong");
  AST_POWER_MASK: assert property ((PORT_POWER & ~pmask) == 15'h0)
    else $error("power on absent port");
  AST_POWER_WRITE: assert property (REG_REQ.wr && REG_REQ.addr == OFS_PORT_POWER |=> PORT_POWER == (POWER_SWITCH ? ($past(wpow) & pmask) : pmask))
    else $error("power write wrong");
  AST_FLS_WRITE: assert property (REG_REQ.wr && REG_REQ.addr == OFS_COMMAND |=> FRAME_LIST_LEN == ($past(frame_list_size) == 2'h1 ? LEN_512 : $past(frame_list_size) == 2'h2 ? LEN_256 : LEN_1024))
    else $error("frame list length wrong");
  AST_ROUTE_STABLE: assert property ($past(RST_N, 2) |-> $stable(PORT_COMPANION))
    else $error("route output moved");
endmodule : hs_caps_asserts

bind hs_host_capability_params hs_caps_asserts #(.NUM_PORTS(NUM_PORTS), .POWER_SWITCH(POWER_SWITCH))
  i_asserts (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .REG_REQ(REG_REQ), .REG_RSP(REG_RSP),
  .PORT_COMPANION(PORT_COMPANION), .PORT_POWER(PORT_POWER), .FRAME_LIST_LEN(FRAME_LIST_LEN));

/* File: verif/hs_host_capability_params_test.sv */
// self-checking bench for the capability register bank
`timescale 1ns/100ps
module hs_host_capability_params_test;
  import hs_caps_pkg::*;
  logic                 core_clk;
  logic                 rst_n;
  reg_req_s             req;
  reg_rsp_s             rsp;
  logic [ROUTE_W-1:0]   companion;
  logic [MAX_PORTS-1:0] power;
  logic [10:0]          flen;
  reg_rsp_s             rsp2;
  logic [ROUTE_W-1:0]   companion2;
  logic [MAX_PORTS-1:0] power2;
  logic [10:0]          flen2;
  logic [31:0]          rnd;
  int                   n_errors;
  int                   tests_run;
  hs_host_capability_params #(.NUM_CC(4'h2), .ROUTE_TABLE(60'h10)) i_dut (.CORE_CLK(core_clk),
    .RST_N(rst_n), .REG_REQ(req), .REG_RSP(rsp), .PORT_COMPANION(companion),
    .PORT_POWER(power), .FRAME_LIST_LEN(flen));
  // consecutive routing, no power switches
  hs_host_capability_params #(.NUM_PORTS(4'h5), .NUM_CC(4'h3), .ROUTE_RULE(1'b0),
    .POWER_SWITCH(1'b0)) i_dut_consec (.CORE_CLK(core_clk), .RST_N(rst_n), .REG_REQ(req),
    .REG_RSP(rsp2), .PORT_COMPANION(companion2), .PORT_POWER(power2),
    .FRAME_LIST_LEN(flen2));
  ////////////////////////////////////////////////////////////////////////////
  // clock
  initial core_clk = 1'b0;
  always #2.5 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////////////////
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      n_errors++;
    end
  endtask : chk
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    req.addr <= a;
    req.rd   <= 1'b1;
    @(posedge core_clk);
    req.rd <= 1'b0;
    #1;
    chk({31'h0, rsp.valid}, 32'h1);
    chk(rsp.data, exp);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    req.addr  <= a;
    req.wdata <= d;
    req.wr    <= 1'b1;
    @(posedge core_clk);
    req.wr <= 1'b0;
    #1;
  endtask : wr
  function automatic logic [31:0] exp_len(input logic [1:0] f);
    return (f == 2'h1) ? 32'(LEN_512) : (f == 2'h2) ? 32'(LEN_256) : 32'(LEN_1024);
  endfunction : exp_len
  task automatic end_sim;
    $display("tests_run %0d n_errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim
  ////////////////////////////////////////////////////////////////////////////
  // watchdog
  initial begin
    #50000;
    n_errors++;
    end_sim();
  end
  // main sequence
  initial begin
    req       = '0;
    rst_n     = 1'b0;
    n_errors  = 0;
    tests_run = 0;
    rnd       = $urandom(32'h2c6e08e5);
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(OFS_CAP_PARAMS, 32'h12);
    rd(OFS_STRUCT_PARAMS, 32'h2292);
    chk(rsp2.data, 32'h3205);
    rd(OFS_ROUTE_LO, 32'h10);
    chk(rsp2.data, 32'h21100);
    rd(OFS_ROUTE_HI, 32'h0);
    rd(OFS_COMMAND, 32'h0);
    chk(32'(flen), 32'(LEN_1024));
    chk(32'(flen2), 32'(LEN_1024));
    chk(companion[31:0], 32'h10);
    chk(companion2[31:0], 32'h21100);
    chk(32'(power), 32'h0);
    chk(32'(power2), 32'h1F);
    $display("reset values done");
    for (int i = 0; i < 4; i++) begin
      rnd = $urandom;
      wr(OFS_CAP_PARAMS, rnd);
      wr(OFS_STRUCT_PARAMS, ~rnd);
      rd(OFS_CAP_PARAMS, 32'h12);
      rd(OFS_STRUCT_PARAMS, 32'h2292);
      rd(8'h7C, 32'h0);
    end
    $display("read-only done");
    // frame list base alignment is left to software
    for (int i = 0; i < 8; i++) begin
      rnd      = $urandom;
      rnd[3:2] = 2'(i);
      wr(OFS_COMMAND, rnd);
      chk(32'(flen), exp_len(rnd[3:2]));
      chk(32'(flen2), exp_len(rnd[3:2]));
      rd(OFS_COMMAND, rnd & 32'hC);
    end
    $display("frame list done");
    for (int i = 0; i < 6; i++) begin
      rnd = $urandom;
      wr(OFS_PORT_POWER, rnd);
      chk(32'(power), rnd & 32'h3);
      chk(32'(power2), 32'h1F);
      rd(OFS_PORT_POWER, rnd & 32'h3);
      chk(rsp2.data, 32'h1F);
    end
    $display("port power done");
    end_sim();
  end
endmodule : hs_host_capability_params_test
